// ===== hw/pmrc_pkg.sv
// Constants and types shared by the power mode and reset control block
package pmrc_pkg;

   // Brownout thresholds in millivolts
   localparam int PMRC_BOD_LOW_MV = 2500;
   localparam int PMRC_BOD_HIGH_MV = 3800;
   localparam logic [11:0] PMRC_BOD_LOW_CODE = 12'(PMRC_BOD_LOW_MV);
   localparam logic [11:0] PMRC_BOD_HIGH_CODE = 12'(PMRC_BOD_HIGH_MV);

   // Bit positions inside the software visible bytes
   localparam int PMRC_AUXC_BOD_BIT = 6;
   localparam int PMRC_AUXC_BOI_BIT = 5;
   localparam int PMRC_AUX_LVMEM_BIT = 4;
   localparam int PMRC_POWER_CONTROL_REG_IDLE_BIT = 0;
   localparam int PMRC_POWER_CONTROL_REG_PD_BIT = 1;
   localparam int PMRC_POWER_CONTROL_REG_POF_BIT = 4;
   localparam int PMRC_POWER_CONTROL_REG_BOF_BIT = 5;

   // Counts in CPU clocks
   localparam int PMRC_CNT_W = 11;
   localparam logic [PMRC_CNT_W-1:0] PMRC_STARTUP_XTAL_CLKS = 11'h400;
   localparam logic [PMRC_CNT_W-1:0] PMRC_STARTUP_RC_CLKS = 11'h100;
   localparam logic [PMRC_CNT_W-1:0] PMRC_WDT_RESET_CLKS = 11'h010;

   // Values after reset
   localparam logic [7:0] PMRC_BYTE_RESET = 8'h00;
   localparam logic PMRC_POF_RESET = 1'b1;

   // Wake source indices
   localparam int PMRC_NSRC = 7;
   localparam int PMRC_SRC_EXT0 = 0;
   localparam int PMRC_SRC_EXT1 = 1;
   localparam int PMRC_SRC_KBI = 2;
   localparam int PMRC_SRC_CMP1 = 3;
   localparam int PMRC_SRC_CMP2 = 4;
   localparam int PMRC_SRC_WDT = 5;
   localparam int PMRC_SRC_BOD = 6;

   typedef struct packed {
      logic brownout_level_select;
      logic reset_pin_disable_cfg;
      logic watchdog_enable_cfg;
      logic osc_is_crystal;
   } pmrc_cfg_t;

   typedef struct packed {
      logic ext0;
      logic ext1;
      logic kbi;
      logic cmp1;
      logic cmp2;
      logic wdt;
   } pmrc_src_t;

   typedef enum logic [1:0] {
      PMRC_ST_RUN,
      PMRC_ST_IDLE,
      PMRC_ST_PDOWN,
      PMRC_ST_START
   } pmrc_state_t;

endpackage

// ===== hw/pmrc_down_counter.sv
// Loadable down counter that reports busy while counting
`timescale 1ns/1ps
module pmrc_down_counter
   import pmrc_pkg::*;
#(
   parameter int W = PMRC_CNT_W
) (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic load,
   input wire logic [W-1:0] load_value,
   output logic busy
);
   logic [W-1:0] count_reg;
   logic [W-1:0] count_next;
   logic busy_next;

   assign count_next = load ? load_value :
                       (count_reg != '0) ? count_reg - 1'b1 : count_reg;
   assign busy_next = (count_next != '0);

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         count_reg <= '0;
         busy <= 1'b0;
      end else begin
         count_reg <= count_next;
         busy <= busy_next;
      end
   end
endmodule // pmrc_down_counter

// ===== hw/pmrc_power_mode_reset_control.sv
// Power mode, brownout, wake-up and reset control of the microcontroller
// Notes on behaviour
// - Threshold 2.5 V when level select is 1, 3.8 V when 0.
// - Brownout disable bit 6 stops all brownout resets and interrupts.
// - Power-on sets the power-on flag; only software clears it.
// - Idle request halts execution; enabled interrupt or reset ends idle.
// - Power-down request stops the oscillator and enters power-down.
// - Power-down ends on reset or enabled, higher-priority wake interrupt.
// - Watchdog overflow from its own oscillator still resets in power-down.
// - Brownout in reset mode forces reset at once, in every state.
// - Brownout in enabled interrupt mode wakes from power-down.
// - Wake restarts oscillator, waits 1024 clocks crystal, else 256.
// - Brownout detector, watchdog and comparators stay powered in power-down.
// - External interrupts 0/1 wake only when their enable is set.
// - Keyboard wakes only when feature enabled and its interrupt enabled.
// - Comparators wake only when enabled and their interrupt enabled.
// - Watchdog overflow is a wake reset when watchdog enable cfg set.
// - Watchdog overflow is a wake interrupt when cfg clear, irq enabled.
// - Brownout wakes by reset when disable and interrupt select clear.
// - Brownout wakes by interrupt when select set and irq enabled.
// - Reset pin wakes power-down only when the pin function is enabled.
// - Low-voltage memory bit 4 powers analog down; only power-on clears.
// - Internal power-on reset always asserts reset at power-up.
// - With pin cfg 0 the shared pin is an active-low reset input.
// - Brownout resets by default; bit 5 set makes it an interrupt.
// - Brownout interrupt once per falling crossing; needs global and own enable.
// - Any brownout detection sets brownout flag until software clears it.
`timescale 1ns/1ps
module pmrc_power_mode_reset_control
   import pmrc_pkg::*;
(
   input wire logic mclk,
   input wire logic rstn,
   input wire pmrc_cfg_t user_config_byte,
   input wire logic brownout_detect_raw,
   input wire logic shared_reset_port_pin,
   input wire logic watchdog_overflow_raw,
   input wire pmrc_src_t wake_req,
   input wire pmrc_src_t wake_irq_enable,
   input wire logic kbi_configured,
   input wire logic cmp1_configured,
   input wire logic cmp2_configured,
   input wire logic global_irq_enable,
   input wire logic brownout_irq_enable,
   input wire logic [PMRC_NSRC-1:0] wake_prio_high,
   input wire logic in_service_high,
   input wire logic in_service_low,
   input wire logic any_enabled_irq,
   input wire logic brownout_irq_ack,
   input wire logic power_control_wr,
   input wire logic [7:0] power_control_wdata,
   input wire logic aux_control_wr,
   input wire logic [7:0] aux_control_wdata,
   input wire logic aux_wr,
   input wire logic [7:0] aux_wdata,
   output logic [7:0] power_control_reg,
   output logic [7:0] aux_control_reg,
   output logic [7:0] aux_reg,
   output logic [11:0] brownout_threshold_mv,
   output logic brownout_det_enable,
   output logic brownout_irq,
   output logic cpu_reset,
   output logic cpu_halt,
   output logic osc_enable,
   output logic peripherals_run,
   output logic always_on_enable,
   output logic memory_analog_off
);
   // Two-stage synchronisers for asynchronous inputs
   logic [2:0] sync1_reg;
   logic [2:0] sync2_reg;
   logic bod_level;
   logic pin_level;
   logic wdt_level;
   logic bod_det_d_reg;
   logic wdt_d_reg;

   pmrc_state_t state_reg;
   pmrc_state_t state_next;
   logic poweron_flag;
   logic brownout_flag;
   logic idle_request;
   logic powerdown_request;
   logic brownout_disable;
   logic brownout_irq_select;
   logic low_voltage_memory_mode;
   logic bod_pending_reg;
   logic reset_in_start_reg;

   logic bod_det;
   logic bod_edge;
   logic bod_reset;
   logic pin_reset;
   logic wdt_event;
   logic wdt_reset_evt;
   logic wdt_reset_busy;
   logic sys_reset;
   logic [PMRC_NSRC-1:0] wake_src;
   logic [PMRC_NSRC-1:0] prio_ok;
   logic wake_irq;
   logic bod_irq_serviceable;
   logic start_load;
   logic start_busy;
   logic [PMRC_CNT_W-1:0] start_count;
   logic pd_entry;
   logic idle_entry;

   assign bod_level = sync2_reg[0];
   assign pin_level = sync2_reg[1];
   assign wdt_level = sync2_reg[2];

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         sync1_reg <= 3'h2;
         sync2_reg <= 3'h2;
         bod_det_d_reg <= 1'b0;
         wdt_d_reg <= 1'b0;
      end else begin
         sync1_reg <= {watchdog_overflow_raw, shared_reset_port_pin, brownout_detect_raw};
         sync2_reg <= sync1_reg;
         bod_det_d_reg <= bod_det;
         wdt_d_reg <= wdt_level;
      end
   end

   // Reset sources
   assign bod_det = bod_level & ~brownout_disable;
   assign bod_reset = bod_det & ~brownout_irq_select;
   assign bod_edge = bod_det & ~bod_det_d_reg & brownout_irq_select;
   assign pin_reset = ~user_config_byte.reset_pin_disable_cfg & ~pin_level;
   assign wdt_event = wdt_level & ~wdt_d_reg;
   // Overflow is a short pulse, so the reset is stretched by a counter
   assign wdt_reset_evt = wdt_event & user_config_byte.watchdog_enable_cfg;
   assign sys_reset = bod_reset | pin_reset | wdt_reset_evt | wdt_reset_busy;

   pmrc_down_counter #(.W(PMRC_CNT_W)) u_wdt_stretch (
      .mclk(mclk),
      .rstn(rstn),
      .load(wdt_reset_evt),
      .load_value(PMRC_WDT_RESET_CLKS),
      .busy(wdt_reset_busy)
   );

   // Wake qualification per source
   assign wake_src[PMRC_SRC_EXT0] = wake_req.ext0 & wake_irq_enable.ext0;
   assign wake_src[PMRC_SRC_EXT1] = wake_req.ext1 & wake_irq_enable.ext1;
   assign wake_src[PMRC_SRC_KBI] = wake_req.kbi & kbi_configured & wake_irq_enable.kbi;
   assign wake_src[PMRC_SRC_CMP1] = wake_req.cmp1 & cmp1_configured & wake_irq_enable.cmp1;
   assign wake_src[PMRC_SRC_CMP2] = wake_req.cmp2 & cmp2_configured & wake_irq_enable.cmp2;
   assign wake_src[PMRC_SRC_WDT] = wdt_event & ~user_config_byte.watchdog_enable_cfg
                                   & wake_irq_enable.wdt;
   assign wake_src[PMRC_SRC_BOD] = bod_edge & brownout_irq_enable;
   // A high source beats only low work; a low source needs nothing in service
   assign prio_ok = wake_prio_high & {PMRC_NSRC{~in_service_high}}
                  | ~wake_prio_high & {PMRC_NSRC{~(in_service_high | in_service_low)}};
   assign wake_irq = global_irq_enable & |(wake_src & prio_ok);

   assign bod_irq_serviceable = bod_pending_reg & global_irq_enable & brownout_irq_enable;

   // Mode requests from the power control write
   assign pd_entry = power_control_wr & power_control_wdata[PMRC_POWER_CONTROL_REG_PD_BIT];
   assign idle_entry = power_control_wr & power_control_wdata[PMRC_POWER_CONTROL_REG_IDLE_BIT];

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         PMRC_ST_RUN: begin
            if (pd_entry)
               state_next = PMRC_ST_PDOWN;
            else if (idle_entry)
               state_next = PMRC_ST_IDLE;
         end
         PMRC_ST_IDLE: begin
            if (any_enabled_irq | bod_irq_serviceable)
               state_next = PMRC_ST_RUN;
         end
         PMRC_ST_PDOWN: begin
            if (wake_irq | sys_reset)
               state_next = PMRC_ST_START;
         end
         PMRC_ST_START: begin
            if (!start_busy && !start_load)
               state_next = PMRC_ST_RUN;
         end
         default: state_next = PMRC_ST_RUN;
      endcase
      // Reset leaves idle at once; power-down still needs the oscillator start
      if (sys_reset && state_reg == PMRC_ST_IDLE)
         state_next = PMRC_ST_RUN;
   end

   assign start_load = (state_reg == PMRC_ST_PDOWN) && (state_next == PMRC_ST_START);
   assign start_count = user_config_byte.osc_is_crystal ? PMRC_STARTUP_XTAL_CLKS
                                                        : PMRC_STARTUP_RC_CLKS;

   pmrc_down_counter #(.W(PMRC_CNT_W)) u_osc_start (
      .mclk(mclk),
      .rstn(rstn),
      .load(start_load),
      .load_value(start_count),
      .busy(start_busy)
   );

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn)
         state_reg <= PMRC_ST_RUN;
      else
         state_reg <= state_next;
   end

   // Flags: a hardware set wins over a software clear in the same cycle
   logic poweron_flag_next;
   logic brownout_flag_next;
   assign poweron_flag_next = (power_control_wr & ~power_control_wdata[PMRC_POWER_CONTROL_REG_POF_BIT])
                            ? 1'b0 : poweron_flag;
   assign brownout_flag_next = bod_det |
                               ((power_control_wr & ~power_control_wdata[PMRC_POWER_CONTROL_REG_BOF_BIT])
                               ? 1'b0 : brownout_flag);

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         poweron_flag <= PMRC_POF_RESET;
         brownout_flag <= 1'b0;
         low_voltage_memory_mode <= 1'b0;
      end else begin
         poweron_flag <= poweron_flag_next;
         brownout_flag <= brownout_flag_next;
         // Sticky until power-on; no software path clears it
         low_voltage_memory_mode <= low_voltage_memory_mode
                                  | (aux_wr & aux_wdata[PMRC_AUX_LVMEM_BIT]);
      end
   end

   // Software control bits, cleared by any reset
   logic idle_request_next;
   logic powerdown_request_next;
   logic bod_pending_next;
   assign idle_request_next = (state_next == PMRC_ST_IDLE);
   assign powerdown_request_next = (state_next == PMRC_ST_PDOWN);
   assign bod_pending_next = bod_edge | (bod_pending_reg & ~brownout_irq_ack);

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         idle_request <= 1'b0;
         powerdown_request <= 1'b0;
         brownout_disable <= 1'b0;
         brownout_irq_select <= 1'b0;
         bod_pending_reg <= 1'b0;
      end else begin
         idle_request <= idle_request_next & ~sys_reset;
         powerdown_request <= powerdown_request_next & ~sys_reset;
         if (sys_reset) begin
            brownout_disable <= 1'b0;
            brownout_irq_select <= 1'b0;
         end else if (aux_control_wr) begin
            brownout_disable <= aux_control_wdata[PMRC_AUXC_BOD_BIT];
            brownout_irq_select <= aux_control_wdata[PMRC_AUXC_BOI_BIT];
         end
         bod_pending_reg <= bod_pending_next & ~sys_reset;
      end
   end

   // A reset that wakes power-down keeps the CPU in reset through start-up
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn)
         reset_in_start_reg <= 1'b0;
      else if (start_load && sys_reset)
         reset_in_start_reg <= 1'b1;
      else if (state_reg != PMRC_ST_START && state_reg != PMRC_ST_PDOWN)
         reset_in_start_reg <= 1'b0;
   end

   // Registered outputs
   logic [7:0] power_control_reg_view;
   logic [7:0] auxc_view;
   logic [7:0] aux_view;
   logic cpu_halt_next;
   assign power_control_reg_view = PMRC_BYTE_RESET
                    | (8'(poweron_flag_next) << PMRC_POWER_CONTROL_REG_POF_BIT)
                    | (8'(brownout_flag_next) << PMRC_POWER_CONTROL_REG_BOF_BIT)
                    | (8'(idle_request_next & ~sys_reset) << PMRC_POWER_CONTROL_REG_IDLE_BIT)
                    | (8'(powerdown_request_next & ~sys_reset) << PMRC_POWER_CONTROL_REG_PD_BIT);
   assign auxc_view = PMRC_BYTE_RESET
                    | (8'(brownout_disable) << PMRC_AUXC_BOD_BIT)
                    | (8'(brownout_irq_select) << PMRC_AUXC_BOI_BIT);
   assign aux_view = PMRC_BYTE_RESET
                   | (8'(low_voltage_memory_mode) << PMRC_AUX_LVMEM_BIT);
   assign cpu_halt_next = (state_next != PMRC_ST_RUN);

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         power_control_reg <= PMRC_BYTE_RESET;
         aux_control_reg <= PMRC_BYTE_RESET;
         aux_reg <= PMRC_BYTE_RESET;
         brownout_threshold_mv <= PMRC_BOD_LOW_CODE;
         brownout_det_enable <= 1'b1;
         brownout_irq <= 1'b0;
         cpu_reset <= 1'b1;
         cpu_halt <= 1'b0;
         osc_enable <= 1'b1;
         peripherals_run <= 1'b1;
         always_on_enable <= 1'b1;
         memory_analog_off <= 1'b0;
      end else begin
         power_control_reg <= power_control_reg_view;
         aux_control_reg <= auxc_view;
         aux_reg <= aux_view;
         brownout_threshold_mv <= user_config_byte.brownout_level_select
                                ? PMRC_BOD_LOW_CODE : PMRC_BOD_HIGH_CODE;
         brownout_det_enable <= ~brownout_disable;
         brownout_irq <= bod_irq_serviceable;
         cpu_reset <= sys_reset | reset_in_start_reg | (start_load & sys_reset);
         cpu_halt <= cpu_halt_next;
         osc_enable <= (state_next != PMRC_ST_PDOWN);
         peripherals_run <= (state_next != PMRC_ST_PDOWN);
         // Detector, watchdog and comparators are never gated by power-down
         always_on_enable <= 1'b1;
         memory_analog_off <= low_voltage_memory_mode;
      end
   end

endmodule // pmrc_power_mode_reset_control

// ===== tb/pmrc_power_mode_reset_control_monitor.sv
// Port-level assertions for the power mode and reset control block
`timescale 1ns/1ps
module pmrc_power_mode_reset_control_chk
   import pmrc_pkg::*;
(
   input wire logic mclk,
   input wire logic rstn,
   input wire pmrc_cfg_t user_config_byte,
   input wire logic brownout_detect_raw,
   input wire logic shared_reset_port_pin,
   input wire logic watchdog_overflow_raw,
   input wire logic any_enabled_irq,
   input wire logic global_irq_enable,
   input wire logic brownout_irq_enable,
   input wire logic power_control_wr,
   input wire logic [7:0] power_control_wdata,
   input wire logic [7:0] power_control_reg,
   input wire logic [7:0] aux_control_reg,
   input wire logic [11:0] brownout_threshold_mv,
   input wire logic brownout_irq,
   input wire logic cpu_reset,
   input wire logic cpu_halt,
   input wire logic osc_enable,
   input wire logic memory_analog_off
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rstn);
   logic [10:0] wake_cnt;
   always_ff @(posedge mclk or negedge rstn)
      if (!rstn)
         wake_cnt <= '0;
      else
         wake_cnt <= !osc_enable ? 11'h001
                   : (wake_cnt != '0 && cpu_halt) ? wake_cnt + 11'h001 : '0;
   AST_THRESH: assert property ($past(rstn) && $stable(user_config_byte) |->
      brownout_threshold_mv == (user_config_byte.brownout_level_select ?
      PMRC_BOD_LOW_CODE : PMRC_BOD_HIGH_CODE)) else $error("threshold mismatch");
   AST_BOD_RST: assert property ($rose(brownout_detect_raw) && !aux_control_reg[6] &&
      !aux_control_reg[5] |-> ##[2:4] cpu_reset) else $error("no brownout reset");
   AST_BOD_IRQ: assert property (brownout_irq |->
      $past(global_irq_enable) && $past(brownout_irq_enable)) else $error("irq ungated");
   AST_POF_SW: assert property ($fell(power_control_reg[4]) |->
      $past(power_control_wr) && !$past(power_control_wdata[4])) else $error("flag lost");
   AST_LVMEM: assert property (!$fell(memory_analog_off))
      else $error("memory mode cleared");
   AST_IDLE_EXIT: assert property (power_control_reg[0] && any_enabled_irq |->
      ##[1:2] !cpu_halt && !power_control_reg[0]) else $error("idle not left");
   AST_PD_OSC: assert property (power_control_reg[1] |-> !osc_enable && cpu_halt)
      else $error("oscillator on in power-down");
   AST_START_RC: assert property ($rose(osc_enable) && !cpu_reset &&
      !user_config_byte.osc_is_crystal |-> ##250 cpu_halt ##[1:12] !cpu_halt)
      else $error("short start-up");
   AST_START_XTAL: assert property ($fell(cpu_halt) && wake_cnt != '0 && !cpu_reset &&
      user_config_byte.osc_is_crystal |-> wake_cnt >= 11'h3fc && wake_cnt <= 11'h407)
      else $error("crystal start-up wrong");
   AST_PIN_RST: assert property ((!shared_reset_port_pin &&
      !user_config_byte.reset_pin_disable_cfg) [*4] |-> cpu_reset) else $error("pin reset");
   AST_WDT_RST: assert property ($rose(watchdog_overflow_raw) &&
      user_config_byte.watchdog_enable_cfg |-> ##[2:4] cpu_reset ##1 cpu_reset [*8])
      else $error("watchdog reset");
endmodule // pmrc_power_mode_reset_control_chk

bind pmrc_power_mode_reset_control pmrc_power_mode_reset_control_chk chk_u (
   .mclk, .rstn, .user_config_byte, .brownout_detect_raw, .shared_reset_port_pin,
   .watchdog_overflow_raw, .any_enabled_irq, .global_irq_enable, .brownout_irq_enable,
   .power_control_wr, .power_control_wdata, .power_control_reg, .aux_control_reg,
   .brownout_threshold_mv, .brownout_irq, .cpu_reset, .cpu_halt, .osc_enable,
   .memory_analog_off);

// ===== tb/pmrc_power_mode_reset_control_tb_top.sv
// Self-checking bench for the power mode and reset control block
`timescale 1ns/1ps
module pmrc_power_mode_reset_control_tb_top;
   import pmrc_pkg::*;
   logic mclk = 1'h0;
   logic rstn = 1'h0;
   pmrc_cfg_t user_config_byte = 4'hc;
   logic brownout_detect_raw = 1'h0, watchdog_overflow_raw = 1'h0;
   logic shared_reset_port_pin = 1'h1;
   pmrc_src_t wake_req = '0, wake_irq_enable = '0;
   logic kbi_configured = 1'h0, cmp1_configured = 1'h0, cmp2_configured = 1'h0;
   logic global_irq_enable = 1'h1, brownout_irq_enable = 1'h1;
   logic [PMRC_NSRC-1:0] wake_prio_high = '1;
   logic in_service_high = 1'h0, in_service_low = 1'h0, any_enabled_irq = 1'h0;
   logic brownout_irq_ack = 1'h0, power_control_wr = 1'h0, aux_control_wr = 1'h0;
   logic aux_wr = 1'h0;
   logic [7:0] power_control_wdata = '0, aux_control_wdata = '0, aux_wdata = '0;
   logic [7:0] power_control_reg, aux_control_reg, aux_reg;
   logic [11:0] brownout_threshold_mv;
   logic brownout_det_enable, brownout_irq, cpu_reset, cpu_halt, osc_enable;
   logic peripherals_run, always_on_enable, memory_analog_off;
   int error_cnt = 0;
   int compares = 0;

   pmrc_power_mode_reset_control dut_u (
      .mclk, .rstn, .user_config_byte, .brownout_detect_raw, .shared_reset_port_pin,
      .watchdog_overflow_raw, .wake_req, .wake_irq_enable, .kbi_configured,
      .cmp1_configured, .cmp2_configured, .global_irq_enable, .brownout_irq_enable,
      .wake_prio_high, .in_service_high, .in_service_low, .any_enabled_irq,
      .brownout_irq_ack, .power_control_wr, .power_control_wdata, .aux_control_wr,
      .aux_control_wdata, .aux_wr, .aux_wdata, .power_control_reg, .aux_control_reg,
      .aux_reg, .brownout_threshold_mv, .brownout_det_enable, .brownout_irq, .cpu_reset,
      .cpu_halt, .osc_enable, .peripherals_run, .always_on_enable, .memory_analog_off);

   always #2 mclk = ~mclk;

   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask

   // A three-bit select strobes the write ports; wdata is shared
   task automatic wr(input logic [2:0] sel, input logic [7:0] d);
      @(posedge mclk);
      {power_control_wr, aux_control_wr, aux_wr} <= sel;
      power_control_wdata <= d;
      aux_control_wdata <= d;
      aux_wdata <= d;
      @(posedge mclk);
      {power_control_wr, aux_control_wr, aux_wr} <= 3'h0;
      cyc(1);
   endtask

   task automatic wait_run(input int lo, input int hi, input string what);
      int n;
      n = 0;
      while ((cpu_halt !== 1'h0 || cpu_reset !== 1'h0) && n < hi + 20) begin
         cyc(1);
         n++;
      end
      chk(what, 16'(n >= lo && n <= hi), 16'h1);
   endtask

   task automatic enter_pd();
      wr(3'h4, 8'h02);
      chk("pd_osc", osc_enable, 1'h0);
      chk("pd_periph", peripherals_run, 1'h0);
   endtask

   task automatic ack_bod();
      @(posedge mclk);
      brownout_irq_ack <= 1'h1;
      @(posedge mclk);
      brownout_irq_ack <= 1'h0;
      cyc(3);
   endtask

   task automatic t_power_on();
      cyc(4);
      chk("thr_low", brownout_threshold_mv, PMRC_BOD_LOW_CODE);
      chk("pof_set", power_control_reg[4], 1'h1);
      chk("always_on", always_on_enable, 1'h1);
      wr(3'h4, 8'h00);
      chk("pof_clr", power_control_reg[4], 1'h0);
      @(posedge mclk);
      user_config_byte.brownout_level_select <= 1'h0;
      cyc(3);
      chk("thr_high", brownout_threshold_mv, PMRC_BOD_HIGH_CODE);
      @(posedge mclk);
      user_config_byte.brownout_level_select <= 1'h1;
      wr(3'h1, 8'h10);
      chk("mem_off", memory_analog_off, 1'h1);
      chk("aux", aux_reg, 8'h10);
      wr(3'h1, 8'h00);
      chk("mem_kept", memory_analog_off, 1'h1);
      @(posedge mclk);
      rstn <= 1'h0;
      cyc(2);
      chk("por_reset", cpu_reset, 1'h1);
      @(posedge mclk);
      rstn <= 1'h1;
      cyc(4);
      chk("mem_por", memory_analog_off, 1'h0);
      chk("pof_again", power_control_reg[4], 1'h1);
      wr(3'h4, 8'h00);
      $display("test power_on done");
   endtask

   task automatic t_idle();
      wr(3'h4, 8'h01);
      cyc(5);
      chk("idle_halt", cpu_halt, 1'h1);
      chk("idle_periph", peripherals_run, 1'h1);
      @(posedge mclk);
      any_enabled_irq <= 1'h1;
      cyc(3);
      chk("idle_exit", cpu_halt, 1'h0);
      chk("idle_bit", power_control_reg[0], 1'h0);
      @(posedge mclk);
      any_enabled_irq <= 1'h0;
      $display("test idle done");
   endtask

   // Each of ext0, ext1, kbi, cmp1 and cmp2 is first offered unqualified, then qualified
   task automatic t_wake();
      for (int s = 0; s < 5; s++) begin
         @(posedge mclk);
         user_config_byte.osc_is_crystal <= (s == 0);
         in_service_high <= (s == 1);
         enter_pd();
         @(posedge mclk);
         wake_req <= pmrc_src_t'(6'h20 >> s);
         wake_irq_enable <= (s < 2) ? '0 : pmrc_src_t'(6'h20 >> s);
         cyc(6);
         chk("unqualified", osc_enable, 1'h0);
         @(posedge mclk);
         wake_irq_enable <= pmrc_src_t'(6'h20 >> s);
         {kbi_configured, cmp1_configured, cmp2_configured} <= 3'h7;
         cyc(6);
         chk("prio", osc_enable, 1'(s != 1));
         @(posedge mclk);
         in_service_high <= 1'h0;
         wait_run(s == 0 ? 1005 : 240, s == 0 ? 1032 : 264, "startup");
         chk("pd_bit", power_control_reg[1], 1'h0);
         @(posedge mclk);
         wake_req <= '0;
         wake_irq_enable <= '0;
         {kbi_configured, cmp1_configured, cmp2_configured} <= 3'h0;
      end
      $display("test wake done");
   endtask

   task automatic t_brownout();
      enter_pd();
      @(posedge mclk);
      brownout_detect_raw <= 1'h1;
      cyc(5);
      chk("bod_reset", cpu_reset, 1'h1);
      chk("bod_osc", osc_enable, 1'h1);
      chk("bod_flag", power_control_reg[5], 1'h1);
      cyc(300);
      chk("bod_hold", cpu_reset, 1'h1);
      @(posedge mclk);
      brownout_detect_raw <= 1'h0;
      wait_run(1, 10, "bod_release");
      chk("bof_kept", power_control_reg[5], 1'h1);
      wr(3'h4, 8'h00);
      chk("bof_clr", power_control_reg[5], 1'h0);
      wr(3'h2, 8'h40);
      chk("det_off", brownout_det_enable, 1'h0);
      chk("auxc", aux_control_reg, 8'h40);
      @(posedge mclk);
      brownout_detect_raw <= 1'h1;
      cyc(8);
      chk("off_noreset", cpu_reset, 1'h0);
      chk("off_noirq", brownout_irq, 1'h0);
      @(posedge mclk);
      brownout_detect_raw <= 1'h0;
      brownout_irq_enable <= 1'h0;
      wr(3'h2, 8'h20);
      chk("det_on", brownout_det_enable, 1'h1);
      @(posedge mclk);
      brownout_detect_raw <= 1'h1;
      cyc(5);
      chk("irq_gated", brownout_irq, 1'h0);
      chk("irq_noreset", cpu_reset, 1'h0);
      @(posedge mclk);
      brownout_irq_enable <= 1'h1;
      cyc(3);
      chk("irq_fire", brownout_irq, 1'h1);
      ack_bod();
      chk("irq_once", brownout_irq, 1'h0);
      @(posedge mclk);
      brownout_detect_raw <= 1'h0;
      enter_pd();
      @(posedge mclk);
      brownout_detect_raw <= 1'h1;
      cyc(5);
      chk("irq_wake", osc_enable, 1'h1);
      chk("irq_wake_rst", cpu_reset, 1'h0);
      wait_run(235, 264, "irq_start");
      @(posedge mclk);
      brownout_detect_raw <= 1'h0;
      ack_bod();
      wr(3'h6, 8'h00);
      $display("test brownout done");
   endtask

   task automatic t_watchdog();
      @(posedge mclk);
      user_config_byte.watchdog_enable_cfg <= 1'h1;
      enter_pd();
      @(posedge mclk);
      watchdog_overflow_raw <= 1'h1;
      cyc(5);
      chk("wdt_reset", cpu_reset, 1'h1);
      chk("wdt_osc", osc_enable, 1'h1);
      @(posedge mclk);
      watchdog_overflow_raw <= 1'h0;
      user_config_byte.watchdog_enable_cfg <= 1'h0;
      wake_irq_enable.wdt <= 1'h1;
      wait_run(230, 264, "wdt_start");
      enter_pd();
      @(posedge mclk);
      watchdog_overflow_raw <= 1'h1;
      cyc(5);
      chk("wdt_irq_wake", osc_enable, 1'h1);
      chk("wdt_irq_rst", cpu_reset, 1'h0);
      wait_run(230, 264, "wdt_irq_start");
      @(posedge mclk);
      watchdog_overflow_raw <= 1'h0;
      wake_irq_enable <= '0;
      $display("test watchdog done");
   endtask

   task automatic t_pin();
      enter_pd();
      @(posedge mclk);
      shared_reset_port_pin <= 1'h0;
      cyc(6);
      chk("pin_ignored", osc_enable, 1'h0);
      @(posedge mclk);
      user_config_byte.reset_pin_disable_cfg <= 1'h0;
      cyc(5);
      chk("pin_reset", cpu_reset, 1'h1);
      chk("pin_wake", osc_enable, 1'h1);
      cyc(300);
      chk("pin_hold", cpu_reset, 1'h1);
      @(posedge mclk);
      shared_reset_port_pin <= 1'h1;
      wait_run(1, 10, "pin_release");
      $display("test pin done");
   endtask

   task automatic results();
      $display("compares %0d mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // Run is near 4000 cycles
   initial begin
      #100000;
      error_cnt++;
      $display("[FAIL] watchdog expired");
      results();
   end

   initial begin
      repeat (12) @(posedge mclk);
      rstn <= 1'h1;
      t_power_on();
      t_idle();
      t_wake();
      t_brownout();
      t_watchdog();
      t_pin();
      results();
   end
endmodule // pmrc_power_mode_reset_control_tb_top
